// *** verilog/ubs_pkg.sv ***
// Overview of operation
// - bank switching acts only while the enable bit of bank control is set
// - the two low bits of bank control form the selected bank code
// - with bank switching on, port three top pin drives address bit 17
// - with bank switching on, port three data bit 7 never reaches the pin
// - each port four pin is either plain i/o or a chip select output
// - a two-pin input port is readable and can wake the device
// - read strobe is low for every external read; external data only then
// - write strobe is low for every external write; memory captures on it
// - address latch pulse marks each access so the low byte can be latched
// - low address byte and data share the eight-line two-way bus
// - the full sixteen-bit address is held latched on its own outputs
package ubs_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] UBS_P3_DATA = 8'h00;
  localparam logic [7:0] UBS_P3_DIR = 8'h01;
  localparam logic [7:0] UBS_BANK_CTRL = 8'h02;
  localparam logic [7:0] UBS_P4_DATA = 8'h03;
  localparam logic [7:0] UBS_P4_DIR = 8'h04;
  localparam logic [7:0] UBS_CS_EN = 8'h05;
  localparam logic [7:0] UBS_WAKE_PORT = 8'h06;
  localparam logic [7:0] UBS_P1_DATA = 8'h90;
  localparam logic [7:0] UBS_P1_DIR = 8'h91;
  localparam logic [7:0] UBS_IRQ_STATE = 8'h92;
  localparam logic [7:0] UBS_P2_DATA = 8'hd8;
  localparam logic [7:0] UBS_P2_DIR = 8'hd9;
  localparam logic [7:0] UBS_CLK_CTRL = 8'hda;

  // field positions
  localparam int UBS_BANK_EN_BIT = 2;
  localparam int UBS_BANK_HI_BIT = 1;
  localparam int UBS_BANK_LO_BIT = 0;
  localparam int UBS_A17_PIN = 7;
  localparam int UBS_WAKE_EN_LSB = 2;

  // values after reset
  localparam logic [7:0] UBS_DATA_RST = 8'h00;
  localparam logic [7:0] UBS_DIR_RST = 8'h00;
  localparam logic [7:0] UBS_CTRL_RST = 8'h00;

  // external bus timing in ref_clk cycles
  localparam logic [2:0] UBS_STROBE_LAST = 3'h3;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_HOLD,
    BUS_STROBE,
    BUS_END
  } ubs_bus_state_t;

endpackage

// *** verilog/ubs_port_if.sv ***
`timescale 1ns/1ns
// settings and pin state of one eight-bit user port
interface ubs_port_if;
  logic [7:0] data;
  logic [7:0] dir;
  logic [7:0] ovr_en;
  logic [7:0] ovr_val;
  logic [7:0] pin_in;
  modport ctrl (output data, output dir, output ovr_en, output ovr_val, input pin_in);
  modport port (input data, input dir, input ovr_en, input ovr_val, output pin_in);
endinterface

// *** verilog/ubs_pin_port.sv ***
`timescale 1ns/1ns
module ubs_pin_port (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // settings from the register file
  ubs_port_if.port cfg,
  // pins
  input logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);

  logic [7:0] meta_q;
  logic [7:0] sync_q;

  // two-flop synchroniser, pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign cfg.pin_in = sync_q;

  // an override (bank address, chip select) beats both data and direction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_o <= 8'h00;
      pin_oe <= 8'h00;
    end else begin
      pin_o <= (cfg.ovr_en & cfg.ovr_val) | (~cfg.ovr_en & cfg.data);
      pin_oe <= cfg.ovr_en | cfg.dir;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  dir_follows_a: assert property (##1 (pin_oe == $past(cfg.ovr_en | cfg.dir)))
    else $error("pin enable does not follow direction");
  data_follows_a: assert property (
    ##1 ((pin_o & ~$past(cfg.ovr_en)) == ($past(cfg.data) & ~$past(cfg.ovr_en))))
    else $error("pin level does not follow port data");

endmodule // ubs_pin_port

// *** verilog/ubs_user_io.sv ***
`timescale 1ns/1ns
module ubs_user_io (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // register port
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_we,
  input logic reg_re,
  output logic [7:0] reg_rdata,
  // external access request from the core
  input logic ext_req,
  input logic ext_write,
  input logic [15:0] ext_addr,
  input logic [7:0] ext_wdata,
  output logic ext_busy,
  output logic ext_done,
  output logic [7:0] ext_rdata,
  // external bus pins
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  input logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic [7:0] ad_oe,
  output logic [15:0] addr_o,
  // user ports one to four, index 0 is port one
  input logic [3:0][7:0] port_i,
  output logic [3:0][7:0] port_o,
  output logic [3:0][7:0] port_oe,
  // wake inputs and interrupt pin levels
  input logic [1:0] wake_i,
  output logic wake,
  input logic [2:0] irq_pin_i
);

  ubs_pkg::ubs_bus_state_t state_q;
  logic [7:0] pdata_q [4];
  logic [7:0] pdir_q [4];
  logic [7:0] pin_state [4];
  logic [7:0] ovr_en [4];
  logic [7:0] ovr_val [4];
  logic [7:0] bank_q;
  logic [7:0] cs_en_q;
  logic [7:0] clk_ctrl_q;
  logic [1:0] wake_en_q;
  logic [7:0] cs_n_q;
  logic [7:0] cs_hit;
  logic [2:0] cnt_q;
  logic op_write_q;
  logic [7:0] wdata_q;
  logic [7:0] ad_meta_q;
  logic [7:0] ad_sync_q;
  logic [1:0] wake_meta_q;
  logic [1:0] wake_sync_q;
  logic [2:0] irq_meta_q;
  logic [2:0] irq_sync_q;
  logic bank_on;

  ubs_port_if pif [4] ();

  assign bank_on = bank_q[ubs_pkg::UBS_BANK_EN_BIT];

  // per-port override: port three bit 7 for bank address, port four for selects
  always_comb begin
    ovr_en[0] = 8'h00;
    ovr_val[0] = 8'h00;
    ovr_en[1] = 8'h00;
    ovr_val[1] = 8'h00;
    ovr_en[2] = 8'h00;
    ovr_val[2] = 8'h00;
    if (bank_on) begin
      ovr_en[2][ubs_pkg::UBS_A17_PIN] = 1'b1;
    end
    // only one bank line exists, so the low code bit gives address bit 17
    ovr_val[2][ubs_pkg::UBS_A17_PIN] = bank_q[ubs_pkg::UBS_BANK_LO_BIT];
    ovr_en[3] = cs_en_q;
    ovr_val[3] = cs_n_q;
  end

  // one pin block per user port
  for (genvar g = 0; g < 4; g++) begin : g_port
    assign pif[g].data = pdata_q[g];
    assign pif[g].dir = pdir_q[g];
    assign pif[g].ovr_en = ovr_en[g];
    assign pif[g].ovr_val = ovr_val[g];
    assign pin_state[g] = pif[g].pin_in;
    ubs_pin_port u_port (
      .ref_clk(ref_clk),
      .reset(reset),
      .cfg(pif[g]),
      .pin_i(port_i[g]),
      .pin_o(port_o[g]),
      .pin_oe(port_oe[g])
    );
  end

  // chip select regions: eight 8k windows picked by address bits 15..13
  for (genvar c = 0; c < 8; c++) begin : g_cs
    assign cs_hit[c] = (state_q != ubs_pkg::BUS_IDLE) && (addr_o[15:13] == 3'(c));
  end

  // active-low selects, registered so port four sees a clean level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_n_q <= 8'hff;
    end else begin
      cs_n_q <= ~cs_hit;
    end
  end

  // synchronisers for bus data, wake and interrupt pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ad_meta_q <= 8'h00;
      ad_sync_q <= 8'h00;
      wake_meta_q <= 2'h0;
      wake_sync_q <= 2'h0;
      irq_meta_q <= 3'h0;
      irq_sync_q <= 3'h0;
    end else begin
      ad_meta_q <= ad_i;
      ad_sync_q <= ad_meta_q;
      wake_meta_q <= wake_i;
      wake_sync_q <= wake_meta_q;
      irq_meta_q <= irq_pin_i;
      irq_sync_q <= irq_meta_q;
    end
  end

  // wake is a level: any enabled wake pin that is high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake <= 1'b0;
    end else begin
      wake <= |(wake_en_q & wake_sync_q);
    end
  end

  // register writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int k = 0; k < 4; k++) begin
        pdata_q[k] <= ubs_pkg::UBS_DATA_RST;
        pdir_q[k] <= ubs_pkg::UBS_DIR_RST;
      end
      bank_q <= ubs_pkg::UBS_CTRL_RST;
      cs_en_q <= ubs_pkg::UBS_CTRL_RST;
      clk_ctrl_q <= ubs_pkg::UBS_CTRL_RST;
      wake_en_q <= 2'h0;
    end else if (reg_we) begin
      unique case (reg_addr)
        ubs_pkg::UBS_P1_DATA: pdata_q[0] <= reg_wdata;
        ubs_pkg::UBS_P1_DIR: pdir_q[0] <= reg_wdata;
        ubs_pkg::UBS_P2_DATA: pdata_q[1] <= reg_wdata;
        ubs_pkg::UBS_P2_DIR: pdir_q[1] <= reg_wdata;
        // bit 7 is stored even while it cannot reach the pin
        ubs_pkg::UBS_P3_DATA: pdata_q[2] <= reg_wdata;
        ubs_pkg::UBS_P3_DIR: pdir_q[2] <= reg_wdata;
        ubs_pkg::UBS_P4_DATA: pdata_q[3] <= reg_wdata;
        ubs_pkg::UBS_P4_DIR: pdir_q[3] <= reg_wdata;
        ubs_pkg::UBS_BANK_CTRL: bank_q <= {5'h00, reg_wdata[2:0]};
        ubs_pkg::UBS_CS_EN: cs_en_q <= reg_wdata;
        ubs_pkg::UBS_WAKE_PORT: begin
          wake_en_q <= reg_wdata[ubs_pkg::UBS_WAKE_EN_LSB +: 2];
        end
        ubs_pkg::UBS_CLK_CTRL: clk_ctrl_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        ubs_pkg::UBS_P1_DATA: reg_rdata <= pin_state[0];
        ubs_pkg::UBS_P1_DIR: reg_rdata <= pdir_q[0];
        ubs_pkg::UBS_IRQ_STATE: reg_rdata <= {5'h00, irq_sync_q};
        ubs_pkg::UBS_P2_DATA: reg_rdata <= pin_state[1];
        ubs_pkg::UBS_P2_DIR: reg_rdata <= pdir_q[1];
        ubs_pkg::UBS_P3_DATA: reg_rdata <= pin_state[2];
        ubs_pkg::UBS_P3_DIR: reg_rdata <= pdir_q[2];
        ubs_pkg::UBS_P4_DATA: reg_rdata <= pin_state[3];
        ubs_pkg::UBS_P4_DIR: reg_rdata <= pdir_q[3];
        ubs_pkg::UBS_BANK_CTRL: reg_rdata <= bank_q;
        ubs_pkg::UBS_CS_EN: reg_rdata <= cs_en_q;
        ubs_pkg::UBS_WAKE_PORT: reg_rdata <= {4'h0, wake_en_q, wake_sync_q};
        ubs_pkg::UBS_CLK_CTRL: reg_rdata <= clk_ctrl_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // external bus sequencer: address phase, hold, strobe, release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ubs_pkg::BUS_IDLE;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      ad_o <= 8'h00;
      ad_oe <= 8'h00;
      addr_o <= 16'h0000;
      op_write_q <= 1'b0;
      wdata_q <= 8'h00;
      cnt_q <= 3'h0;
      ext_busy <= 1'b0;
      ext_done <= 1'b0;
      ext_rdata <= 8'h00;
    end else begin
      ext_done <= 1'b0;
      unique case (state_q)
        ubs_pkg::BUS_IDLE: begin
          if (ext_req) begin
            state_q <= ubs_pkg::BUS_ADDR;
            ale <= 1'b1;
            ad_o <= ext_addr[7:0];
            ad_oe <= 8'hff;
            addr_o <= ext_addr;
            op_write_q <= ext_write;
            wdata_q <= ext_wdata;
            ext_busy <= 1'b1;
          end
        end
        ubs_pkg::BUS_ADDR: begin
          // low byte stays on the bus one cycle past the falling latch edge
          state_q <= ubs_pkg::BUS_HOLD;
          ale <= 1'b0;
        end
        ubs_pkg::BUS_HOLD: begin
          state_q <= ubs_pkg::BUS_STROBE;
          cnt_q <= 3'h0;
          if (op_write_q) begin
            wr_n <= 1'b0;
            ad_o <= wdata_q;
            ad_oe <= 8'hff;
          end else begin
            rd_n <= 1'b0;
            ad_oe <= 8'h00;
          end
        end
        ubs_pkg::BUS_STROBE: begin
          if (cnt_q == ubs_pkg::UBS_STROBE_LAST) begin
            state_q <= ubs_pkg::BUS_END;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            // sample late: the synchroniser costs two cycles of the strobe
            if (!op_write_q) begin
              ext_rdata <= ad_sync_q;
            end
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ubs_pkg::BUS_END: begin
          // write data held one cycle after the rising strobe
          state_q <= ubs_pkg::BUS_IDLE;
          ad_oe <= 8'h00;
          ext_busy <= 1'b0;
          ext_done <= 1'b1;
        end
        // unused state codes fall back to idle rather than lock the bus
        default: begin
          state_q <= ubs_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_latch;
    ale ##1 !ale;
  endsequence

  sequence s_read_low;
    (!rd_n && wr_n) [*4];
  endsequence

  sequence s_write_low;
    (!wr_n && rd_n) [*4];
  endsequence

  // busy spans accept to end of strobe release
  sequence s_busy_run;
    ext_busy [*7];
  endsequence

  bank_pin_a: assert property (
    bank_on && $past(bank_on) && !$past(reset) |->
      port_oe[2][7] && (port_o[2][7] == $past(bank_q[0])))
    else $error("port three top pin is not the bank address");

  bank_ignore_a: assert property (
    bank_on && $past(bank_on) && ($past(bank_q) == bank_q) && ($past(bank_q, 2) == bank_q) |->
      $stable(port_o[2][7]))
    else $error("port three data bit 7 reached the pin");

  plain_io_a: assert property (
    !bank_on && !$past(bank_on) && !$past(reset) |->
      port_oe[2][7] == $past(pdir_q[2][7]))
    else $error("port three top pin not plain i/o while bank is off");

  cs_pin_a: assert property (
    cs_en_q[0] && $past(cs_en_q[0]) && !$past(reset) |->
      port_oe[3][0] && (port_o[3][0] == $past(cs_n_q[0])))
    else $error("port four pin does not carry its chip select");

  read_cycle_a: assert property (
    $rose(ale) && !op_write_q |-> s_latch ##1 s_read_low ##1 (rd_n ##1 ext_done))
    else $error("read cycle sequence broken");

  write_cycle_a: assert property (
    $rose(ale) && op_write_q |-> s_latch ##1 s_write_low ##1 (wr_n && ad_oe == 8'hff))
    else $error("write cycle sequence broken");

  read_float_a: assert property (!rd_n |-> ad_oe == 8'h00)
    else $error("bus driven while read strobe low");

  low_byte_a: assert property (ale |-> ad_oe == 8'hff && ad_o == addr_o[7:0])
    else $error("low address byte missing during latch pulse");

  addr_hold_a: assert property (
    state_q != ubs_pkg::BUS_IDLE && $past(state_q) != ubs_pkg::BUS_IDLE |-> $stable(addr_o))
    else $error("latched address moved during access");

  wake_level_a: assert property (
    ##1 (wake == $past(|(wake_en_q & wake_sync_q))))
    else $error("wake output does not follow enabled pins");

  busy_span_a: assert property (
    $rose(ale) |-> s_busy_run ##1 (!ext_busy && ext_done))
    else $error("busy or done out of step with the access");

  cs_low_a: assert property (
    state_q != ubs_pkg::BUS_IDLE |=> !cs_n_q[addr_o[15:13]])
    else $error("chip select not asserted for the addressed window");

  ale_strobe_a: assert property (ale |-> rd_n && wr_n)
    else $error("strobe low during address latch pulse");

endmodule // ubs_user_io

// *** sim/ubs_ext_mem.sv ***
`timescale 1ns/1ns
module ubs_ext_mem (
  // clock
  input wire logic ref_clk,
  // strobes from the device
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // shared bus and pacing
  input wire logic [7:0] ad,
  input wire logic slow,
  output logic [7:0] mem_o
);
  logic [7:0] mem [256];
  logic [7:0] lat_q = 8'h00;
  logic [7:0] flt_q = 8'h5a;
  logic rd_seen_q = 1'b0;
  // low address byte taken from the shared bus on the latch pulse
  always @(posedge ref_clk) if (ale) lat_q <= ad;
  // write data taken while the write strobe is low
  always @(posedge ref_clk) if (!wr_n) mem[lat_q] <= ad;
  // slow mode holds the data back one cycle into the strobe
  always @(posedge ref_clk) rd_seen_q <= !rd_n;
  // a released bus toggles so a stale value never passes for data
  always @(posedge ref_clk) flt_q <= ~flt_q;
  // data driven only while the read strobe is low
  assign mem_o = (!rd_n && (!slow || rd_seen_q)) ? mem[lat_q] : flt_q;
endmodule // ubs_ext_mem

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_we = 1'b0, reg_re = 1'b0, ext_req = 1'b0, ext_write = 1'b0, slow = 1'b0;
  logic [15:0] ext_addr = 16'h0000, addr_o;
  logic [7:0] ext_wdata = 8'h00, ext_rdata, ad_i, ad_o, ad_oe, mem_o, rd_v, dv, dd;
  logic ext_busy, ext_done, ale, rd_n, wr_n, wake;
  logic [3:0][7:0] port_i, port_o, port_oe;
  logic [3:0][7:0] pins_q = '0;
  logic [1:0] wake_i = 2'h0;
  logic [2:0] irq_pin_i = 3'h0;
  logic [7:0] exp_mem [256];
  logic [15:0] xa_l [8];
  int n_fail = 0;
  int total_checks = 0;

  // wire levels from the device's enables; memory and pins_q fill the rest
  assign ad_i = (ad_oe & ad_o) | (~ad_oe & mem_o);
  assign port_i = (port_oe & port_o) | (~port_oe & pins_q);

  ubs_user_io u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .ext_req(ext_req), .ext_write(ext_write), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_busy(ext_busy), .ext_done(ext_done), .ext_rdata(ext_rdata), .ale(ale),
    .rd_n(rd_n), .wr_n(wr_n), .ad_i(ad_i), .ad_o(ad_o), .ad_oe(ad_oe), .addr_o(addr_o),
    .port_i(port_i), .port_o(port_o), .port_oe(port_oe), .wake_i(wake_i), .wake(wake),
    .irq_pin_i(irq_pin_i));
  ubs_ext_mem u_mem (.ref_clk(ref_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad(ad_i),
    .slow(slow), .mem_o(mem_o));

  // free-running core clock
  always #20 ref_clk = ~ref_clk;

  function automatic logic [7:0] data_off(input int g);
    case (g)
      0: return ubs_pkg::UBS_P1_DATA;
      1: return ubs_pkg::UBS_P2_DATA;
      2: return ubs_pkg::UBS_P3_DATA;
      default: return ubs_pkg::UBS_P4_DATA;
    endcase
  endfunction
  function automatic logic [7:0] pin_level(input logic [7:0] dir, dat, ext);
    return (dir & dat) | (~dir & ext);
  endfunction
  function automatic logic bank_level(input logic [7:0] ctl, dat);
    return ctl[2] ? ctl[0] : dat[7];
  endfunction

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h0, got}, {24'h0, exp});
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // one external access; again repeats the request while busy
  task automatic ext_access(input logic w, input logic [15:0] a, input logic [7:0] d,
                            input logic again, input logic exp_cs, input logic slw);
    int n_ale, n_lo, n_bad, n_done, n_busy;
    logic cs_seen;
    n_ale = 0;
    n_lo = 0;
    n_bad = 0;
    n_done = 0;
    n_busy = 0;
    cs_seen = 1'b0;
    @(posedge ref_clk);
    ext_req <= 1'b1;
    ext_write <= w;
    ext_addr <= a;
    ext_wdata <= d;
    slow <= slw;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      ext_req <= (i == 0) ? again : 1'b0;
      #1;
      if (ale === 1'b1) begin
        n_ale++;
        chk8(ad_o & ad_oe, a[7:0]);
        chk32({16'h0, addr_o}, {16'h0, a});
      end
      if ((w ? wr_n : rd_n) === 1'b0) begin
        n_lo++;
        if (w) chk8(ad_o & ad_oe, d);
      end
      if ((w ? rd_n : wr_n) !== 1'b1) n_bad++;
      if (ext_done === 1'b1) n_done++;
      if (ext_busy === 1'b1) n_busy++;
      if (port_o[3][a[15:13]] === 1'b0 && port_oe[3][a[15:13]] === 1'b1) cs_seen = 1'b1;
    end
    chk32(32'(n_ale), 32'h1);
    chk32(32'(n_lo), 32'h4);
    chk32(32'(n_bad), 32'h0);
    chk32(32'(n_done), 32'h1);
    // busy from the accept edge up to the cycle before done
    chk32(32'(n_busy), 32'h7);
    chk1(cs_seen, exp_cs);
    chk32({16'h0, addr_o}, {16'h0, a});
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #(40 * 8000);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    void'($urandom(32'h6512));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    // idle levels after reset
    chk1(rd_n, 1'b1);
    chk1(wr_n, 1'b1);
    chk1(ale, 1'b0);
    chk8(ad_oe, 8'h00);
    chk32(port_oe, 32'h0);
    chk1(ext_busy, 1'b0);
    chk1(wake, 1'b0);
    for (int g = 0; g < 4; g++) begin
      reg_rd(data_off(g) + 8'h01, rd_v);
      chk8(rd_v, ubs_pkg::UBS_DIR_RST);
    end
    reg_rd(ubs_pkg::UBS_BANK_CTRL, rd_v);
    chk8(rd_v, ubs_pkg::UBS_CTRL_RST);
    $display("test reset done");
    // direction per pin on every port
    for (int g = 0; g < 4; g++) begin
      dv = (g == 0) ? 8'hff : 8'($urandom);
      dd = 8'($urandom);
      reg_wr(data_off(g) + 8'h01, dv);
      reg_wr(data_off(g), dd);
      pins_q[g] <= 8'($urandom);
      repeat (3) @(posedge ref_clk);
      #1;
      chk8(port_oe[g], dv);
      chk8(port_o[g] & dv, dd & dv);
      reg_rd(data_off(g), rd_v);
      chk8(rd_v, pin_level(dv, dd, pins_q[g]));
    end
    $display("test ports done");
    // every bank code with switching on and off
    reg_wr(ubs_pkg::UBS_P3_DIR, 8'h80);
    for (int i = 0; i < 8; i++) begin
      dv = {5'h0, 3'(i)};
      dd = {~dv[0], 7'($urandom)};
      reg_wr(ubs_pkg::UBS_P3_DATA, dd);
      reg_wr(ubs_pkg::UBS_BANK_CTRL, dv);
      repeat (3) @(posedge ref_clk);
      #1;
      chk1(port_oe[2][7], 1'b1);
      chk1(port_o[2][7], bank_level(dv, dd));
      reg_rd(ubs_pkg::UBS_BANK_CTRL, rd_v);
      chk8(rd_v, dv);
    end
    reg_wr(ubs_pkg::UBS_BANK_CTRL, 8'h00);
    $display("test bank done");
    // all wake enable and pin combinations
    for (int k = 0; k < 16; k++) begin
      reg_wr(ubs_pkg::UBS_WAKE_PORT, {4'h0, 2'(k >> 2), 2'h0});
      wake_i <= 2'(k);
      repeat (5) @(posedge ref_clk);
      #1;
      chk1(wake, |(2'(k >> 2) & 2'(k)));
      reg_rd(ubs_pkg::UBS_WAKE_PORT, rd_v);
      chk8(rd_v & 8'h0f, 8'(k));
    end
    @(posedge ref_clk);
    irq_pin_i <= 3'($urandom);
    reg_wr(ubs_pkg::UBS_IRQ_STATE, 8'hff);
    repeat (3) @(posedge ref_clk);
    reg_rd(ubs_pkg::UBS_IRQ_STATE, rd_v);
    chk8(rd_v, {5'h0, irq_pin_i});
    $display("test wake done");
    // writes then reads across all eight chip selects
    reg_wr(ubs_pkg::UBS_CS_EN, 8'hff);
    for (int i = 0; i < 8; i++) begin
      xa_l[i] = {3'(i), 5'($urandom), 8'h20 + 8'(i)};
      dd = 8'($urandom);
      exp_mem[xa_l[i][7:0]] = dd;
      ext_access(1'b1, xa_l[i], dd, i == 0, 1'b1, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      ext_access(1'b0, xa_l[i], 8'($urandom), i == 7, 1'b1, 1'(i));
      chk8(ext_rdata, exp_mem[xa_l[i][7:0]]);
    end
    reg_wr(ubs_pkg::UBS_CS_EN, 8'h00);
    reg_wr(ubs_pkg::UBS_P4_DIR, 8'h00);
    ext_access(1'b0, xa_l[3], 8'h00, 1'b0, 1'b0, 1'b0);
    chk8(ext_rdata, exp_mem[xa_l[3][7:0]]);
    $display("test bus done");
    // plain stores read back, unmapped place reads zero
    for (int g = 0; g < 6; g++) begin
      dd = 8'($urandom);
      dv = (g < 4) ? data_off(g) + 8'h01 : (g == 4) ? ubs_pkg::UBS_CS_EN : ubs_pkg::UBS_CLK_CTRL;
      reg_wr(dv, dd);
      reg_rd(dv, rd_v);
      chk8(rd_v, dd);
    end
    reg_wr(8'h50, 8'hff);
    reg_rd(8'h50, rd_v);
    chk8(rd_v, 8'h00);
    $display("test registers done");
    report_and_stop;
  end
endmodule // tb
